// ---- src/cpu_regs_pkg.sv ----
// Constants, types and register map of the core register set
// Operation
// - Four 16-bit data words, all four byte-splittable
// - Data word pairs form two 32-bit long operands
// - Two 16-bit address words for pointers and operands
// - Address words pair into a 32-bit address long
// - 16-bit frame base for frame-relative addressing
// - 20-bit vector table base register
// - 20-bit pointer to the next instruction
// - Two 16-bit stack pointers, active one used
// - Stack select 0 picks irq, 1 picks user
// - Hardware interrupt or low soft trap clears stack select
// - 16-bit static base for static-relative addressing
// - Processor state held in an 11-bit flag word
// - Carry flag keeps the ALU carry or shifted bit
// - Zero flag set on zero result, else cleared
// - Negative flag follows the result sign
// - Bank select flag picks register bank 0 or 1
// - Overflow flag set on overflow, else cleared
// - Mask enable gates all maskable interrupts
// - Any interrupt acknowledge clears mask enable
// - Accept request only above 3-bit priority level
// - Reserved flag bit written zero, reads undefined
package cpu_regs_pkg;

    // Byte offsets on the register bus, one aligned word each
    localparam logic [7:0] OFS_GP_WORD_0 = 8'h00;
    localparam logic [7:0] OFS_GP_WORD_1 = 8'h04;
    localparam logic [7:0] OFS_GP_WORD_2 = 8'h08;
    localparam logic [7:0] OFS_GP_WORD_3 = 8'h0C;
    localparam logic [7:0] OFS_ADDR_WORD_0 = 8'h10;
    localparam logic [7:0] OFS_ADDR_WORD_1 = 8'h14;
    localparam logic [7:0] OFS_FRAME_BASE = 8'h18;
    localparam logic [7:0] OFS_VECTOR_BASE = 8'h1C;
    localparam logic [7:0] OFS_NEXT_FETCH = 8'h20;
    localparam logic [7:0] OFS_USER_SP = 8'h24;
    localparam logic [7:0] OFS_IRQ_SP = 8'h28;
    localparam logic [7:0] OFS_STATIC_BASE = 8'h2C;
    localparam logic [7:0] OFS_CPU_FLAGS = 8'h30;
    localparam logic [7:0] OFS_GP_LONG_0 = 8'h34;
    localparam logic [7:0] OFS_GP_LONG_1 = 8'h38;
    localparam logic [7:0] OFS_ADDR_LONG = 8'h3C;
    localparam logic [7:0] OFS_ACTIVE_SP = 8'h40;

    // Banked words: gp_word_0..3 then addr_word_0..1
    localparam int unsigned BANK_WORDS = 6;
    localparam int unsigned GP_WORD_2_ENTRY = 2;
    localparam int unsigned GP_WORD_3_ENTRY = 3;
    localparam int unsigned ADDR_WORD_0_ENTRY = 4;
    localparam int unsigned ADDR_WORD_1_ENTRY = 5;

    localparam logic [15:0] WORD_RESET = 16'h0000;
    localparam logic [19:0] WIDE_RESET = 20'h00000;
    localparam logic [5:0] TRAP_SP_LIMIT = 6'h20;
    localparam int unsigned BYTE_MSB = 7;
    localparam int unsigned WORD_MSB = 15;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Flag word, bit 0 first: c d z s b o i u, ipl in 10:8
    typedef struct packed {
        logic [2:0] cpu_priority_level;
        logic u;
        logic i;
        logic o;
        logic b;
        logic s;
        logic z;
        logic d;
        logic c;
    } flags_s;

    localparam logic [10:0] FLAGS_RESET = 11'h000;

    typedef struct packed {
        logic valid;
        logic byte_op;
        logic [15:0] result;
        logic carry;
        logic overflow;
    } alu_upd_s;

    typedef struct packed {
        logic req;
        logic [2:0] level;
        logic ack;
        logic trap;
        logic [5:0] trap_num;
    } irq_in_s;

    typedef struct packed {
        logic load;
        logic advance;
        logic [19:0] target;
        logic [2:0] step;
    } fetch_ctl_s;

    typedef struct packed {
        logic valid;
        logic [15:0] delta;
    } sp_adj_s;

    typedef struct packed {
        logic [31:0] gp_long_0;
        logic [31:0] gp_long_1;
        logic [31:0] addr_long;
        logic [15:0] active_sp;
        logic [15:0] frame_base;
        logic [15:0] static_base;
        logic [19:0] vector_base;
        logic [19:0] next_fetch;
        flags_s flags;
    } core_view_s;

endpackage

// ---- src/cpu_regs.sv ----
// Core register set with flag word, bank select and bus access
module cpu_regs
    import cpu_regs_pkg::*;
(
    input wire logic clock,
    input wire logic nrst,
    input wire logic [7:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    input wire logic [3:0] byteenable,
    output logic [31:0] readdata,
    output logic waitrequest,
    output logic [1:0] response,
    input wire alu_upd_s alu,
    input wire irq_in_s irq,
    input wire fetch_ctl_s fetch,
    input wire sp_adj_s sp_adj,
    output logic irq_accept,
    output core_view_s view
);

    function automatic logic [31:0] merge(
        input logic [31:0] old_v,
        input logic [31:0] new_v,
        input logic [3:0] lanes
    );
        logic [31:0] m;
        m = old_v;
        for (int k = 0; k < 4; k++) begin
            if (lanes[k]) begin
                m[8*k +: 8] = new_v[8*k +: 8];
            end
        end
        return m;
    endfunction

    logic ack_q;
    logic [31:0] readdata_q;
    logic [1:0] resp_q;
    flags_s flags_q;
    flags_s flags_d;
    logic [15:0] frame_q;
    logic [15:0] frame_d;
    logic [15:0] static_q;
    logic [15:0] static_d;
    logic [19:0] vector_q;
    logic [19:0] vector_d;
    logic [19:0] fetch_q;
    logic [19:0] fetch_d;
    logic [15:0] usp_q;
    logic [15:0] usp_d;
    logic [15:0] isp_q;
    logic [15:0] isp_d;
    logic [15:0] cur_word [0:BANK_WORDS-1];
    logic [31:0] rd_mux;
    logic mapped;

    // One-cycle wait: the request is captured, then answered
    assign waitrequest = (read | write) & ~ack_q;
    wire logic wr_go = write & ack_q & mapped;
    wire logic [31:0] wr_val = merge(rd_mux, writedata, byteenable);
    wire logic wr_flags = wr_go && address == OFS_CPU_FLAGS;
    wire logic wr_frame = wr_go && address == OFS_FRAME_BASE;
    wire logic wr_static = wr_go && address == OFS_STATIC_BASE;
    wire logic wr_vector = wr_go && address == OFS_VECTOR_BASE;
    wire logic wr_fetch = wr_go && address == OFS_NEXT_FETCH;
    wire logic wr_usp = wr_go && address == OFS_USER_SP;
    wire logic wr_isp = wr_go && address == OFS_IRQ_SP;

    wire logic [31:0] gp_long_0 = {cur_word[GP_WORD_2_ENTRY], cur_word[0]};
    wire logic [31:0] gp_long_1 = {cur_word[GP_WORD_3_ENTRY], cur_word[1]};
    wire logic [31:0] addr_long =
        {cur_word[ADDR_WORD_1_ENTRY], cur_word[ADDR_WORD_0_ENTRY]};
    wire logic [15:0] active_sp = flags_q.u ? usp_q : isp_q;
    wire logic trap_low = irq.trap && irq.trap_num < TRAP_SP_LIMIT;
    wire logic zero_res = alu.byte_op ? alu.result[BYTE_MSB:0] == 8'h00
                                      : alu.result == 16'h0000;
    wire logic neg_res = alu.byte_op ? alu.result[BYTE_MSB] : alu.result[WORD_MSB];

    // Read mux; long views are read only, writes to them are dropped
    always_comb begin
        rd_mux = 32'h0000_0000;
        mapped = 1'b1;
        case (address)
            OFS_GP_WORD_0: rd_mux = {16'h0000, cur_word[0]};
            OFS_GP_WORD_1: rd_mux = {16'h0000, cur_word[1]};
            OFS_GP_WORD_2: rd_mux = {16'h0000, cur_word[GP_WORD_2_ENTRY]};
            OFS_GP_WORD_3: rd_mux = {16'h0000, cur_word[GP_WORD_3_ENTRY]};
            OFS_ADDR_WORD_0: rd_mux = {16'h0000, cur_word[ADDR_WORD_0_ENTRY]};
            OFS_ADDR_WORD_1: rd_mux = {16'h0000, cur_word[ADDR_WORD_1_ENTRY]};
            OFS_FRAME_BASE: rd_mux = {16'h0000, frame_q};
            OFS_VECTOR_BASE: rd_mux = {12'h000, vector_q};
            OFS_NEXT_FETCH: rd_mux = {12'h000, fetch_q};
            OFS_USER_SP: rd_mux = {16'h0000, usp_q};
            OFS_IRQ_SP: rd_mux = {16'h0000, isp_q};
            OFS_STATIC_BASE: rd_mux = {16'h0000, static_q};
            OFS_CPU_FLAGS: rd_mux = {21'h000000, flags_q};
            OFS_GP_LONG_0: rd_mux = gp_long_0;
            OFS_GP_LONG_1: rd_mux = gp_long_1;
            OFS_ADDR_LONG: rd_mux = addr_long;
            OFS_ACTIVE_SP: rd_mux = {16'h0000, active_sp};
            default: mapped = 1'b0;
        endcase
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            ack_q <= 1'b0;
            readdata_q <= 32'h0000_0000;
            resp_q <= RESP_OKAY;
        end else begin
            ack_q <= (read | write) & ~ack_q;
            if ((read | write) & ~ack_q) begin
                readdata_q <= read ? rd_mux : 32'h0000_0000;
                resp_q <= mapped ? RESP_OKAY : RESP_SLVERR;
            end
        end
    end

    assign readdata = readdata_q;
    assign response = resp_q;

    // Two copies per bankable word; the bank flag steers every access
    for (genvar e = 0; e < BANK_WORDS; e++) begin : g_bank
        logic [1:0][15:0] word_q;
        wire logic hit = wr_go && address[7:2] == OFS_GP_WORD_0[7:2] + 6'(e);
        always_ff @(posedge clock or negedge nrst) begin
            if (!nrst) begin
                word_q <= {WORD_RESET, WORD_RESET};
            end else if (hit) begin
                word_q[flags_q.b] <= wr_val[15:0];
            end
        end
        assign cur_word[e] = word_q[flags_q.b];
    end

    // Core events win over a bus write to the same field in one cycle
    always_comb begin
        flags_d = flags_q;
        if (wr_flags) begin
            flags_d = flags_s'(wr_val[10:0]);
        end
        if (alu.valid) begin
            flags_d.c = alu.carry;
            flags_d.z = zero_res;
            flags_d.s = neg_res;
            flags_d.o = alu.overflow;
        end
        if (irq.ack || irq.trap) begin
            flags_d.i = 1'b0;
        end
        if (irq.ack || trap_low) begin
            flags_d.u = 1'b0;
        end
    end

    always_comb begin
        fetch_d = wr_fetch ? wr_val[19:0] : fetch_q;
        if (fetch.advance) begin
            fetch_d = fetch_q + {17'h00000, fetch.step};
        end
        if (fetch.load) begin
            fetch_d = fetch.target;
        end
    end

    // A stack step hits whichever pointer is active this cycle
    always_comb begin
        usp_d = wr_usp ? wr_val[15:0] : usp_q;
        isp_d = wr_isp ? wr_val[15:0] : isp_q;
        if (sp_adj.valid && flags_q.u) begin
            usp_d = usp_q + sp_adj.delta;
        end
        if (sp_adj.valid && !flags_q.u) begin
            isp_d = isp_q + sp_adj.delta;
        end
    end

    assign frame_d = wr_frame ? wr_val[15:0] : frame_q;
    assign static_d = wr_static ? wr_val[15:0] : static_q;
    assign vector_d = wr_vector ? wr_val[19:0] : vector_q;

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            flags_q <= flags_s'(FLAGS_RESET);
            frame_q <= WORD_RESET;
            static_q <= WORD_RESET;
            vector_q <= WIDE_RESET;
            fetch_q <= WIDE_RESET;
            usp_q <= WORD_RESET;
            isp_q <= WORD_RESET;
        end else begin
            flags_q <= flags_d;
            frame_q <= frame_d;
            static_q <= static_d;
            vector_q <= vector_d;
            fetch_q <= fetch_d;
            usp_q <= usp_d;
            isp_q <= isp_d;
        end
    end

    // Strict compare: an equal level is not enough to interrupt
    assign irq_accept = irq.req & flags_q.i & (irq.level > flags_q.cpu_priority_level);

    assign view.gp_long_0 = gp_long_0;
    assign view.gp_long_1 = gp_long_1;
    assign view.addr_long = addr_long;
    assign view.active_sp = active_sp;
    assign view.frame_base = frame_q;
    assign view.static_base = static_q;
    assign view.vector_base = vector_q;
    assign view.next_fetch = fetch_q;
    assign view.flags = flags_q;

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!nrst);

    AST_WAIT_ONE: assert property (
        (read | write) && waitrequest |=> !waitrequest)
        else $error("bus answer took more than one wait cycle");

    AST_ACTIVE_SP: assert property (
        sp_adj.valid && flags_q.u && !wr_isp |=> $stable(isp_q))
        else $error("stack step reached the idle stack pointer");

    AST_SP_STEP: assert property (
        sp_adj.valid && !flags_q.u && !wr_isp
        |=> isp_q == $past(isp_q) + $past(sp_adj.delta))
        else $error("stack step missed the irq stack pointer");

    AST_U_CLEAR: assert property (
        irq.ack || trap_low |=> !view.flags.u)
        else $error("stack select not cleared on interrupt");

    AST_U_KEEP_HIGH_TRAP: assert property (
        irq.trap && irq.trap_num >= TRAP_SP_LIMIT && !irq.ack
        && !wr_flags && flags_q.u |=> view.flags.u)
        else $error("high soft trap cleared stack select");

    AST_CARRY: assert property (
        alu.valid |=> view.flags.c == $past(alu.carry))
        else $error("carry flag not taken from the ALU");

    AST_ZERO: assert property (
        alu.valid && !alu.byte_op |=> view.flags.z == ($past(alu.result) == 16'h0000))
        else $error("zero flag wrong for word result");

    AST_SIGN: assert property (
        alu.valid |=> view.flags.s == ($past(alu.byte_op)
            ? $past(alu.result[BYTE_MSB]) : $past(alu.result[WORD_MSB])))
        else $error("negative flag wrong");

    AST_OVERFLOW: assert property (
        alu.valid |=> view.flags.o == $past(alu.overflow))
        else $error("overflow flag not taken from the ALU");

    AST_ACCEPT_GATE: assert property (
        irq_accept |-> view.flags.i && irq.req)
        else $error("interrupt accepted while masked");

    AST_PRIORITY: assert property (
        irq.req && view.flags.i && irq.level <= view.flags.cpu_priority_level |-> !irq_accept)
        else $error("interrupt accepted at or below priority level");

    AST_I_CLEAR: assert property (
        irq.ack || irq.trap |=> !view.flags.i ##1 !view.flags.i || $past(wr_flags))
        else $error("mask enable not cleared on acknowledge");

    AST_LONG_PAIR: assert property (
        view.gp_long_0[15:0] == cur_word[0]
        && view.gp_long_1[31:16] == cur_word[GP_WORD_3_ENTRY])
        else $error("long operand halves out of place");

    AST_BANK_SWAP: assert property (
        wr_flags && wr_val[4] != flags_q.b && !alu.valid
        |=> view.flags.b == $past(wr_val[4]))
        else $error("bank select write lost");

    AST_FETCH_LOAD: assert property (
        fetch.load |=> view.next_fetch == $past(fetch.target))
        else $error("next fetch pointer did not load");

    AST_LOW_HALF: assert property (
        wr_go && address == OFS_GP_WORD_0 && byteenable == 4'h1
        |=> view.gp_long_0[7:0] == $past(writedata[7:0]) && $stable(view.gp_long_0[15:8]))
        else $error("low half write of data word 0 wrong");

    AST_HIGH_HALF: assert property (
        wr_go && address == OFS_GP_WORD_0 && byteenable == 4'h2
        |=> view.gp_long_0[15:8] == $past(writedata[15:8]) && $stable(view.gp_long_0[7:0]))
        else $error("high half write of data word 0 wrong");

    AST_GP3_UPPER: assert property (
        wr_go && address == OFS_GP_WORD_3 && byteenable[1:0] == 2'h3
        |=> view.gp_long_1[31:16] == $past(writedata[15:0]))
        else $error("data word 3 not in upper half of long operand");

    AST_RO_LONG: assert property (
        wr_go && address == OFS_GP_LONG_0
        |=> $stable(view.gp_long_0))
        else $error("write changed a read-only long operand");

    AST_ADDR_LOW: assert property (
        wr_go && address == OFS_ADDR_WORD_0 && byteenable[1:0] == 2'h3
        |=> view.addr_long[15:0] == $past(writedata[15:0]))
        else $error("address word 0 write lost");

    AST_ADDR_HIGH: assert property (
        wr_go && address == OFS_ADDR_WORD_1 && byteenable[1:0] == 2'h3
        |=> view.addr_long[31:16] == $past(writedata[15:0]))
        else $error("address word 1 not in upper half of address long");

    AST_FRAME_WR: assert property (
        wr_frame && byteenable[1:0] == 2'h3
        |=> view.frame_base == $past(writedata[15:0]))
        else $error("frame base write lost");

    AST_VECTOR_WR: assert property (
        wr_vector && byteenable[2:0] == 3'h7
        |=> view.vector_base == $past(writedata[19:0]))
        else $error("vector base write lost");

    AST_FETCH_STEP: assert property (
        fetch.advance && !fetch.load
        |=> view.next_fetch == $past(view.next_fetch) + 20'($past(fetch.step)))
        else $error("next fetch pointer did not advance by the step");

    AST_USP_STEP: assert property (
        sp_adj.valid && flags_q.u && !wr_usp
        |=> usp_q == $past(usp_q) + $past(sp_adj.delta))
        else $error("stack step missed the user stack pointer");

    AST_STATIC_WR: assert property (
        wr_static && byteenable[1:0] == 2'h3
        |=> view.static_base == $past(writedata[15:0]))
        else $error("static base write lost");

    AST_BUS_ERROR: assert property (
        (read | write) && waitrequest && address[1:0] != 2'h0
        |=> response == RESP_SLVERR)
        else $error("misaligned access not refused");

    AST_ZERO_BYTE: assert property (
        alu.valid && alu.byte_op
        |=> view.flags.z == ($past(alu.result[BYTE_MSB:0]) == 8'h00))
        else $error("zero flag wrong for byte result");

    AST_BANK_HOLD: assert property (
        !wr_flags
        |=> $stable(view.flags.b))
        else $error("bank select changed without a flag write");

    AST_IPL_KEEP: assert property (
        irq.ack && !wr_flags
        |=> view.flags.cpu_priority_level == $past(view.flags.cpu_priority_level))
        else $error("priority level changed on acknowledge");

    AST_FLAGS_UPPER: assert property (
        read && waitrequest && address == OFS_CPU_FLAGS
        |=> readdata[31:11] == 21'h000000)
        else $error("flag word read shows bits above the word");

    AST_BANK_OTHER: assert property (
        wr_go && address == OFS_GP_WORD_0
        |=> $stable(g_bank[0].word_q[!flags_q.b]))
        else $error("write reached the unselected bank");

    COV_IRQ_ACK: cover property (irq_accept ##1 irq.ack ##1 !view.flags.i);
    COV_LOW_TRAP: cover property (flags_q.u && trap_low ##1 !view.flags.u);
    COV_BANK_ONE: cover property (wr_flags ##1 view.flags.b ##[1:4] wr_go);
    COV_ALU_ZERO: cover property (alu.valid && zero_res ##1 view.flags.z);
    COV_BUS_ERROR: cover property (write && !waitrequest && response == RESP_SLVERR);

endmodule

// ---- testbench/core_side_model.sv ----
// Behavioural task-driven stimulus for the register set's core side: ALU results, interrupts, fetch and stack steps
module core_side_model
    import cpu_regs_pkg::*;
(
    input wire logic clock,
    output alu_upd_s alu,
    output irq_in_s irq,
    output fetch_ctl_s fetch,
    output sp_adj_s sp_adj
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        alu = '0;
        irq = '0;
        fetch = '0;
        sp_adj = '0;
    end
    // Payloads are inverted on release so a stale value never passes for a live one
    task automatic alu_op(input logic b, input logic [15:0] r, input logic c, input logic o);
        @(posedge clock);
        alu <= '{1'b1, b, r, c, o};
        @(posedge clock);
        alu <= '{1'b0, ~b, ~r, ~c, ~o};
    endtask
    task automatic set_req(input logic r, input logic [2:0] l);
        @(posedge clock);
        irq.req <= r;
        irq.level <= l;
    endtask
    task automatic ack();
        @(posedge clock);
        irq.ack <= 1'b1;
        @(posedge clock);
        irq.ack <= 1'b0;
    endtask
    task automatic trap(input logic [5:0] n);
        @(posedge clock);
        irq.trap <= 1'b1;
        irq.trap_num <= n;
        @(posedge clock);
        irq.trap <= 1'b0;
        irq.trap_num <= ~n;
    endtask
    task automatic fetch_op(input logic ld, input logic adv, input logic [19:0] t,
                            input logic [2:0] s);
        @(posedge clock);
        fetch <= '{ld, adv, t, s};
        @(posedge clock);
        fetch <= '{1'b0, 1'b0, ~t, ~s};
    endtask
    task automatic sp_step(input logic [15:0] d);
        @(posedge clock);
        sp_adj <= '{1'b1, d};
        @(posedge clock);
        sp_adj <= '{1'b0, ~d};
    endtask
endmodule

// ---- testbench/tb_cpu_register_set_and_flags.sv ----
// Self-checking bench for the core register set
`define CHK(nm, ex, got) begin \
    cmp_count++; \
    if ((got) !== (ex)) begin \
        n_fail++; \
        $display("BAD %s exp %0h got %0h", nm, ex, got); \
    end \
end
module tb_cpu_register_set_and_flags
    import cpu_regs_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clock, nrst, read, write, waitrequest, irq_accept;
    logic [7:0] address;
    logic [31:0] writedata, readdata, rdat;
    logic [3:0] byteenable;
    logic [1:0] response, rsp;
    alu_upd_s alu;
    irq_in_s irq;
    fetch_ctl_s fetch;
    sp_adj_s sp_adj;
    core_view_s view;
    int n_fail = 0;
    int cmp_count = 0;
    cpu_regs uut (.clock(clock), .nrst(nrst), .address(address), .read(read),
        .write(write), .writedata(writedata), .byteenable(byteenable),
        .readdata(readdata), .waitrequest(waitrequest), .response(response),
        .alu(alu), .irq(irq), .fetch(fetch), .sp_adj(sp_adj),
        .irq_accept(irq_accept), .view(view));
    core_side_model p (.clock(clock), .alu(alu), .irq(irq), .fetch(fetch),
        .sp_adj(sp_adj));
    initial begin
        clock = 1'b0;
        forever #12.5 clock = ~clock;
    end
    task automatic report_and_stop();
        if (n_fail == 0 && cmp_count > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    // Request held until waitrequest is sampled low; a bounded wait stands in for a hang
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                       input logic [3:0] be);
        int i;
        @(posedge clock);
        address <= a;
        writedata <= d;
        byteenable <= be;
        read <= ~w;
        write <= w;
        for (i = 0; i < 20; i++) begin
            @(posedge clock);
            if (waitrequest === 1'b0) break;
        end
        rdat = readdata;
        rsp = response;
        read <= 1'b0;
        write <= 1'b0;
        if (i == 20) begin
            n_fail++;
            report_and_stop();
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus(1'b1, a, d, 4'hF);
    endtask
    task automatic rd(input logic [7:0] a);
        bus(1'b0, a, 32'h0000_0000, 4'hF);
    endtask
    task automatic t_reset();
        @(negedge clock);
        `CHK("accept", 1'b0, irq_accept)
        `CHK("active_sp", 16'h0000, view.active_sp)
        rd(OFS_CPU_FLAGS);
        `CHK("flags", 32'h0000_0000, rdat)
    endtask
    task automatic t_words();
        bus(1'b1, OFS_GP_WORD_0, 32'h0000_00AB, 4'h1);
        bus(1'b1, OFS_GP_WORD_0, 32'h0000_CD99, 4'h2);
        rd(OFS_GP_WORD_0);
        `CHK("gp0", 32'h0000_CDAB, rdat)
        wr(OFS_GP_WORD_2, 32'h0000_1234);
        wr(OFS_GP_WORD_1, 32'h0000_1111);
        wr(OFS_GP_WORD_3, 32'h0000_3333);
        wr(OFS_ADDR_WORD_0, 32'h0000_A0A0);
        wr(OFS_ADDR_WORD_1, 32'h0000_A1A1);
        @(negedge clock);
        `CHK("long0", 32'h1234_CDAB, view.gp_long_0)
        `CHK("long1", 32'h3333_1111, view.gp_long_1)
        `CHK("alon", 32'hA1A1_A0A0, view.addr_long)
        rd(OFS_ADDR_LONG);
        `CHK("alon_rd", 32'hA1A1_A0A0, rdat)
    endtask
    task automatic t_bank();
        wr(OFS_CPU_FLAGS, 32'h0000_0010);
        @(negedge clock);
        `CHK("bank1", 32'h0000_0000, view.gp_long_0)
        wr(OFS_GP_WORD_0, 32'h0000_5555);
        rd(OFS_GP_WORD_0);
        `CHK("b1gp0", 32'h0000_5555, rdat)
        wr(OFS_CPU_FLAGS, 32'h0000_0000);
        rd(OFS_GP_WORD_0);
        `CHK("b0gp0", 32'h0000_CDAB, rdat)
        `CHK("b0long", 32'h1234_CDAB, view.gp_long_0)
    endtask
    task automatic t_refuse();
        wr(OFS_GP_LONG_0, 32'hFFFF_FFFF);
        `CHK("ro_rsp", RESP_OKAY, rsp)
        @(negedge clock);
        `CHK("ro_keep", 32'h1234_CDAB, view.gp_long_0)
        rd(8'h44);
        `CHK("unm_rsp", RESP_SLVERR, rsp)
        `CHK("unm_dat", 32'h0000_0000, rdat)
        wr(8'h01, 32'h0000_0001);
        `CHK("mis_rsp", RESP_SLVERR, rsp)
        rd(OFS_ACTIVE_SP);
        `CHK("sp_rd", 32'h0000_0000, rdat)
    endtask
    task automatic t_wide();
        wr(OFS_VECTOR_BASE, 32'hFFFF_FFFF);
        rd(OFS_VECTOR_BASE);
        `CHK("vbase", 32'h000F_FFFF, rdat)
        wr(OFS_NEXT_FETCH, 32'hFFFF_FFFF);
        rd(OFS_NEXT_FETCH);
        `CHK("nfetch", 32'h000F_FFFF, rdat)
        wr(OFS_FRAME_BASE, 32'h1234_5678);
        rd(OFS_FRAME_BASE);
        `CHK("fbase", 32'h0000_5678, rdat)
        wr(OFS_STATIC_BASE, 32'h0000_9ABC);
        @(negedge clock);
        `CHK("fb_view", 16'h5678, view.frame_base)
        `CHK("sb_view", 16'h9ABC, view.static_base)
        `CHK("vb_view", 20'hFFFFF, view.vector_base)
    endtask
    task automatic t_alu();
        logic [15:0] r [4] = '{16'h0000, 16'h8000, 16'h0100, 16'h0080};
        logic [3:0] bv = 4'b1100;
        logic [3:0] cv = 4'b1001;
        logic [3:0] ov = 4'b1010;
        logic ez, es;
        for (int i = 0; i < 4; i++) begin
            p.alu_op(bv[i], r[i], cv[i], ov[i]);
            @(negedge clock);
            ez = bv[i] ? (r[i][7:0] == 8'h00) : (r[i] == 16'h0000);
            es = bv[i] ? r[i][7] : r[i][15];
            `CHK("c", cv[i], view.flags.c)
            `CHK("z", ez, view.flags.z)
            `CHK("s", es, view.flags.s)
            `CHK("o", ov[i], view.flags.o)
        end
    endtask
    task automatic t_irq();
        wr(OFS_IRQ_SP, 32'h0000_1000);
        wr(OFS_USER_SP, 32'h0000_2000);
        wr(OFS_CPU_FLAGS, 32'h0000_03C0);
        @(negedge clock);
        `CHK("usp_act", 16'h2000, view.active_sp)
        p.sp_step(16'h0002);
        @(negedge clock);
        `CHK("usp_step", 16'h2002, view.active_sp)
        rd(OFS_IRQ_SP);
        `CHK("isp_keep", 32'h0000_1000, rdat)
        p.set_req(1'b1, 3'h3);
        @(negedge clock);
        `CHK("acc_eq", 1'b0, irq_accept)
        p.set_req(1'b1, 3'h4);
        @(negedge clock);
        `CHK("acc_hi", 1'b1, irq_accept)
        wr(OFS_CPU_FLAGS, 32'h0000_0380);
        @(negedge clock);
        `CHK("acc_mask", 1'b0, irq_accept)
        wr(OFS_CPU_FLAGS, 32'h0000_03C0);
        p.ack();
        @(negedge clock);
        `CHK("ack_flg", 11'h300, view.flags)
        `CHK("isp_act", 16'h1000, view.active_sp)
        `CHK("acc_off", 1'b0, irq_accept)
        p.set_req(1'b0, 3'h0);
        p.sp_step(16'hFFFE);
        @(negedge clock);
        `CHK("sp_adj", 16'h0FFE, view.active_sp)
        rd(OFS_USER_SP);
        `CHK("usp_keep", 32'h0000_2002, rdat)
    endtask
    task automatic t_trap();
        wr(OFS_CPU_FLAGS, 32'h0000_00C0);
        p.trap(6'h20);
        @(negedge clock);
        `CHK("trap32", 11'h080, view.flags)
        wr(OFS_CPU_FLAGS, 32'h0000_00C0);
        p.trap(6'h1F);
        @(negedge clock);
        `CHK("trap31", 11'h000, view.flags)
    endtask
    task automatic t_fetch();
        p.fetch_op(1'b1, 1'b0, 20'hABCDE, 3'h0);
        @(negedge clock);
        `CHK("load", 20'hABCDE, view.next_fetch)
        p.fetch_op(1'b0, 1'b1, 20'h00000, 3'h3);
        @(negedge clock);
        `CHK("adv", 20'hABCE1, view.next_fetch)
        p.fetch_op(1'b1, 1'b1, 20'h00010, 3'h7);
        @(negedge clock);
        `CHK("ld_wins", 20'h00010, view.next_fetch)
    endtask
    initial begin
        nrst = 1'b0;
        read = 1'b0;
        write = 1'b0;
        address = 8'h00;
        writedata = 32'h0000_0000;
        byteenable = 4'h0;
        repeat (5) @(posedge clock);
        nrst <= 1'b1;
        t_reset();
        t_words();
        t_bank();
        t_refuse();
        t_wide();
        t_alu();
        t_irq();
        t_trap();
        t_fetch();
        report_and_stop();
    end
endmodule
